// ### chip_select_port.sv
// four-pin programmable chip-select port with extra interrupts
`timescale 1ns/1ps
module chip_select_port (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic bit_wr,
  input wire logic [2:0] bit_sel,
  input wire logic bit_val,
  output logic [7:0] sfr_rdata_ff,
  output logic sfr_hit,
  input wire logic [15:0] xaddr,
  input wire logic xrd_n,
  input wire logic xwr_n,
  input wire logic [3:0] pin_in,
  output logic [3:0] pin_out,
  output logic [3:0] pin_oe_n,
  input wire logic irq_a_ack,
  input wire logic irq_b_ack,
  output logic irq_a_req,
  output logic irq_b_req,
  output logic irq_a_high,
  output logic irq_b_high,
  output logic [7:0] irq_a_vector,
  output logic [7:0] irq_b_vector
);
  import csport_pkg::*;
  logic rst_s1_ff;
  logic rst_n_ff;
  logic [7:0] pol_ff;
  logic [7:0] xictl_ff;
  logic [7:0] cfg_low_ff;
  logic [7:0] cfg_high_ff;
  logic [3:0] pin_data_ff;
  logic [15:0] base_ff [4];
  logic [3:0] strobe;
  logic [3:0] active;
  logic [3:0] pin_in_ff;
  logic a_pin;
  logic b_pin;
  logic a_set;
  logic b_set;
  logic [7:0] nxt_xictl;
  logic [15:0] cfg_all;
  logic [7:0] rdata;
  strobe_cfg_if cfg_bus [4] ();

  // reset released through two flops
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1_ff <= 1'b0;
      rst_n_ff <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_n_ff <= rst_s1_ff;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      pol_ff <= RST_CFG; // [R18]
      cfg_low_ff <= RST_CFG;
      cfg_high_ff <= RST_CFG;
    end else if (sfr_wr) begin
      if (sfr_addr == ADDR_POLARITY) pol_ff <= {sfr_wdata[7:4], 4'h0};
      if (sfr_addr == ADDR_CFG_LOW) cfg_low_ff <= sfr_wdata; // [R10]
      if (sfr_addr == ADDR_CFG_HIGH) cfg_high_ff <= sfr_wdata; // [R9]
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      pin_data_ff <= RST_PIN_DATA; // [R18]
    end else if (sfr_wr && sfr_addr == ADDR_PIN_DATA) begin
      pin_data_ff <= sfr_wdata[3:0];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      for (int i = 0; i < 4; i++) begin
        base_ff[i] <= RST_BASE; // [R18]
      end
    end else if (sfr_wr) begin
      case (sfr_addr) // [R7]
        ADDR_B0_LOW: base_ff[0][7:0] <= sfr_wdata;
        ADDR_B0_HIGH: base_ff[0][15:8] <= sfr_wdata;
        ADDR_B1_LOW: base_ff[1][7:0] <= sfr_wdata;
        ADDR_B1_HIGH: base_ff[1][15:8] <= sfr_wdata;
        ADDR_B2_LOW: base_ff[2][7:0] <= sfr_wdata;
        ADDR_B2_HIGH: base_ff[2][15:8] <= sfr_wdata;
        ADDR_B3_LOW: base_ff[3][7:0] <= sfr_wdata;
        ADDR_B3_HIGH: base_ff[3][15:8] <= sfr_wdata;
        default: ;
      endcase
    end
  end

  // pins zero to three sit in nibbles zero to three [R9] [R10]
  assign cfg_all = {cfg_high_ff, cfg_low_ff};
  generate
    for (genvar g = 0; g < 4; g++) begin : g_pin
      logic [3:0] field;
      assign field = cfg_all[4*g +: 4];
      assign cfg_bus[g].base = base_ff[g];
      assign cfg_bus[g].fn = pin_fn_t'(field[3:2]); // [R1]
      assign cfg_bus[g].cmp = cmp_len_t'(field[1:0]);
      assign cfg_bus[g].pol = pol_ff[POL_LSB + g];
      strobe_decode u_dec (
        .clk(ref_clk),
        .rst_n(rst_n_ff),
        .cfg(cfg_bus[g]),
        .xaddr(xaddr),
        .rd_n(xrd_n),
        .wr_n(xwr_n),
        .strobe_ff(strobe[g]),
        .active(active[g])
      );
      // quasi-bidirectional: only drives low actively in io mode
      assign pin_out[g] = active[g] ? strobe[g] : pin_data_ff[g]; // [R5]
      assign pin_oe_n[g] = active[g] ? 1'b0 : pin_data_ff[g]; // [R19]
    end
  endgenerate

  always_ff @(posedge ref_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      pin_in_ff <= 4'hf;
    end else begin
      pin_in_ff <= pin_in;
    end
  end

  // pin 3 feeds irq a, pin 2 feeds irq b; io mode only [R12]
  assign a_pin = active[3] ? 1'b1 : pin_in[3];
  assign b_pin = active[2] ? 1'b1 : pin_in[2];
  assign a_set = xictl_ff[XI_A_TRIG] && pin_in_ff[3] && !a_pin; // [R14]
  assign b_set = xictl_ff[XI_B_TRIG] && pin_in_ff[2] && !b_pin;

  always_comb begin
    nxt_xictl = xictl_ff;
    if (sfr_wr && sfr_addr == ADDR_XICTL) begin
      nxt_xictl = sfr_wdata;
    end
    if (bit_wr) begin
      nxt_xictl[bit_sel] = bit_val; // [R13]
    end
    if (irq_a_ack && xictl_ff[XI_A_TRIG]) nxt_xictl[XI_A_FLAG] = 1'b0;
    if (irq_b_ack && xictl_ff[XI_B_TRIG]) nxt_xictl[XI_B_FLAG] = 1'b0;
    // set wins over any clear in the same cycle [R15]
    if (a_set) nxt_xictl[XI_A_FLAG] = 1'b1;
    if (b_set) nxt_xictl[XI_B_FLAG] = 1'b1;
  end

  always_ff @(posedge ref_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      xictl_ff <= RST_CFG; // [R18]
    end else begin
      xictl_ff <= nxt_xictl;
    end
  end

  // level mode requests straight from the pin [R14] [R16]
  assign irq_a_req = xictl_ff[XI_A_EN] &&
    (xictl_ff[XI_A_TRIG] ? xictl_ff[XI_A_FLAG] : !a_pin);
  assign irq_b_req = xictl_ff[XI_B_EN] &&
    (xictl_ff[XI_B_TRIG] ? xictl_ff[XI_B_FLAG] : !b_pin);
  assign irq_a_high = xictl_ff[XI_A_PRIO]; // [R16]
  assign irq_b_high = xictl_ff[XI_B_PRIO];
  assign irq_a_vector = VEC_IRQ_A; // [R17]
  assign irq_b_vector = VEC_IRQ_B;

  always_comb begin
    sfr_hit = 1'b1;
    case (sfr_addr)
      ADDR_POLARITY: rdata = pol_ff;
      ADDR_XICTL: rdata = xictl_ff;
      ADDR_CFG_LOW: rdata = cfg_low_ff;
      ADDR_CFG_HIGH: rdata = cfg_high_ff;
      ADDR_PIN_DATA: rdata = {4'h0, pin_in};
      ADDR_B0_LOW: rdata = base_ff[0][7:0];
      ADDR_B0_HIGH: rdata = base_ff[0][15:8];
      ADDR_B1_LOW: rdata = base_ff[1][7:0];
      ADDR_B1_HIGH: rdata = base_ff[1][15:8];
      ADDR_B2_LOW: rdata = base_ff[2][7:0];
      ADDR_B2_HIGH: rdata = base_ff[2][15:8];
      ADDR_B3_LOW: rdata = base_ff[3][7:0];
      ADDR_B3_HIGH: rdata = base_ff[3][15:8];
      default: begin
        rdata = 8'h00;
        sfr_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      sfr_rdata_ff <= 8'h00;
    end else if (sfr_rd) begin
      sfr_rdata_ff <= rdata;
    end
  end
endmodule

// ### csport_pkg.sv
// constants for the programmable chip-select port
// Contract
// [R1] two-bit function field per pin selects mode
// [R2] read mode follows read strobe on match
// [R3] write mode follows write strobe on match
// [R4] read/write mode follows either strobe on match
// [R5] io mode drives port data low nibble
// [R6] match from base, compare length, function
// [R7] sixteen-bit base from high and low bytes
// [R8] compare length masks low address bits
// [R9] high config holds pins three and two
// [R10] low config holds pins one and zero
// [R11] polarity bits seven to four, one high
// [R12] pins two and three feed extra interrupts
// [R13] interrupt control at c0, bit-addressable
// [R14] trigger bit selects falling edge or level
// [R15] edge flag set by hardware, cleared on service
// [R16] enable gates request, priority selects level
// [R17] vectors 33h and 3bh, polled sixth, seventh
// [R18] reset: port ones, all config zero
// [R19] strobe pin idles inactive, ignores data bit
// [R20] match uses full sixteen-bit data address
package csport_pkg;
  localparam logic [7:0] ADDR_POLARITY = 8'hae;
  localparam logic [7:0] ADDR_XICTL = 8'hc0;
  localparam logic [7:0] ADDR_CFG_LOW = 8'hc2;
  localparam logic [7:0] ADDR_CFG_HIGH = 8'hc3;
  localparam logic [7:0] ADDR_PIN_DATA = 8'hd8;
  localparam logic [7:0] ADDR_B0_LOW = 8'h84;
  localparam logic [7:0] ADDR_B0_HIGH = 8'h85;
  localparam logic [7:0] ADDR_B1_LOW = 8'h94;
  localparam logic [7:0] ADDR_B1_HIGH = 8'h95;
  localparam logic [7:0] ADDR_B2_LOW = 8'hac;
  localparam logic [7:0] ADDR_B2_HIGH = 8'had;
  localparam logic [7:0] ADDR_B3_LOW = 8'hb4;
  localparam logic [7:0] ADDR_B3_HIGH = 8'hb5;
  localparam logic [7:0] RST_CFG = 8'h00;
  localparam logic [3:0] RST_PIN_DATA = 4'hf;
  localparam logic [15:0] RST_BASE = 16'h0000;
  // extra_interrupt_control bit positions
  localparam int XI_B_PRIO = 7;
  localparam int XI_B_EN = 6;
  localparam int XI_B_FLAG = 5;
  localparam int XI_B_TRIG = 4;
  localparam int XI_A_PRIO = 3;
  localparam int XI_A_EN = 2;
  localparam int XI_A_FLAG = 1;
  localparam int XI_A_TRIG = 0;
  localparam int POL_LSB = 4;
  localparam logic [7:0] VEC_IRQ_A = 8'h33;
  localparam logic [7:0] VEC_IRQ_B = 8'h3b;
  localparam int POLL_IRQ_A = 6;
  localparam int POLL_IRQ_B = 7;
  typedef enum logic [1:0] {
    FN_IO = 2'b00,
    FN_RD = 2'b01,
    FN_WR = 2'b10,
    FN_RW = 2'b11
  } pin_fn_t;
  typedef enum logic [1:0] {
    CMP_16 = 2'b00,
    CMP_15 = 2'b01,
    CMP_14 = 2'b10,
    CMP_8 = 2'b11
  } cmp_len_t;
endpackage

// ### csport_properties.sv
// assertions on the chip-select port pins, interrupt requests and vectors, and register decode and reads
`timescale 1ns/1ps
module csport_properties
  import csport_pkg::*;
(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_addr,
  input wire logic bit_wr,
  input wire logic [7:0] sfr_rdata_ff,
  input wire logic sfr_hit,
  input wire logic xrd_n,
  input wire logic xwr_n,
  input wire logic [3:0] pin_in,
  input wire logic [3:0] pin_out,
  input wire logic irq_a_ack,
  input wire logic irq_b_ack,
  input wire logic irq_a_req,
  input wire logic irq_b_req,
  input wire logic [7:0] irq_a_vector,
  input wire logic [7:0] irq_b_vector
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  vector_const_a: assert property (
    irq_a_vector == VEC_IRQ_A && irq_b_vector == VEC_IRQ_B)
    else $error("vector wrong");
  addr_map_a: assert property (
    sfr_hit == (sfr_addr inside {8'hae, 8'hc0, 8'hc2, 8'hc3, 8'hd8, 8'h84,
    8'h85, 8'h94, 8'h95, 8'hac, 8'had, 8'hb4, 8'hb5}))
    else $error("decode wrong");
  // three quiet cycles cover the one-cycle strobe lag
  idle_pin_a: assert property (
    (xrd_n && xwr_n && !sfr_wr)[*3] |=> $stable(pin_out))
    else $error("pin moved while idle");
  ack_clear_a: assert property (
    irq_a_ack && !sfr_wr && !bit_wr && pin_in[3] && $past(pin_in[3])
    ##1 pin_in[3] |-> !irq_a_req)
    else $error("request a kept");
  ack_clear_b_a: assert property (
    irq_b_ack && !sfr_wr && !bit_wr && pin_in[2] && $past(pin_in[2])
    ##1 pin_in[2] |-> !irq_b_req)
    else $error("request b kept");
  reset_pins_a: assert property (
    $rose(arst_n) |-> pin_out == 4'hf && !irq_a_req && !irq_b_req)
    else $error("reset state wrong");
  data_read_a: assert property (
    sfr_rd && sfr_addr == ADDR_PIN_DATA && $stable(pin_in)
    && pin_in == $past(pin_in, 2) |=> sfr_rdata_ff == {4'h0, $past(pin_in)})
    else $error("data read wrong");
  pol_read_a: assert property (
    sfr_rd && sfr_addr == ADDR_POLARITY |=> sfr_rdata_ff[3:0] == 4'h0)
    else $error("polarity low nibble set");
  cover property ($rose(irq_a_req));
  cover property ($rose(irq_b_req));
  cover property (!xwr_n ##2 !pin_out[0]);
endmodule
bind chip_select_port csport_properties chk (.*);

// ### pad_model.sv
// pads with pull-ups and a peripheral that can pull lines low
`timescale 1ns/1ps
module pad_model (
  input wire logic [3:0] pin_out,
  input wire logic [3:0] pin_oe_n,
  input wire logic [3:0] pull_low,
  output logic [3:0] pin_in
);
  // released pads rise to the pull-up, never hold a stale value
  assign pin_in = ~pull_low & (pin_oe_n | pin_out);
endmodule

// ### strobe_cfg_if.sv
// per-pin strobe configuration carried to the decoder
`timescale 1ns/1ps
interface strobe_cfg_if;
  import csport_pkg::*;
  logic [15:0] base;
  pin_fn_t fn;
  cmp_len_t cmp;
  logic pol;
  modport src (output base, output fn, output cmp, output pol);
  modport dst (input base, input fn, input cmp, input pol);
endinterface

// ### strobe_decode.sv
// address compare and strobe generation for one pin
`timescale 1ns/1ps
module strobe_decode (
  input wire logic clk,
  input wire logic rst_n,
  strobe_cfg_if.dst cfg,
  input wire logic [15:0] xaddr,
  input wire logic rd_n,
  input wire logic wr_n,
  output logic strobe_ff,
  output logic active
);
  import csport_pkg::*;
  logic [15:0] mask;
  logic hit;
  logic on;
  always_comb begin
    case (cfg.cmp) // [R8]
      CMP_16: mask = 16'hffff;
      CMP_15: mask = 16'hfffe;
      CMP_14: mask = 16'hfffc;
      default: mask = 16'hff00;
    endcase
  end
  // full address used, dptr or page byte alike [R20] [R7] [R6]
  assign hit = ((xaddr ^ cfg.base) & mask) == 16'h0000;
  always_comb begin
    case (cfg.fn)
      FN_RD: on = hit && !rd_n; // [R2]
      FN_WR: on = hit && !wr_n; // [R3]
      FN_RW: on = hit && (!rd_n || !wr_n); // [R4]
      default: on = 1'b0;
    endcase
  end
  assign active = (cfg.fn != FN_IO); // [R1]
  // registered for clean output; one cycle lag versus strobes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      strobe_ff <= 1'b1;
    end else begin
      strobe_ff <= on ~^ cfg.pol; // [R11] [R19]
    end
  end
endmodule

// ### testbench.sv
// bench for the chip-select port
`timescale 1ns/1ps
module testbench;
  import csport_pkg::*;
  logic ref_clk = 0, arst_n = 0, sfr_wr = 0, sfr_rd = 0, bit_wr = 0;
  logic bit_val = 0, xrd_n = 1, xwr_n = 1, irq_a_ack = 0, irq_b_ack = 0;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata_ff;
  logic [7:0] irq_a_vector, irq_b_vector;
  logic [2:0] bit_sel = 3'h0;
  logic [15:0] xaddr = 16'h0000;
  logic [3:0] pin_in, pin_out, pin_oe_n, pull_low = 4'h0;
  logic sfr_hit, irq_a_req, irq_b_req, irq_a_high, irq_b_high;
  int bad_count = 0, samples_checked = 0, cycles = 0;
  logic [7:0] bases [4] = '{8'h84, 8'h94, 8'hac, 8'hb4};
  logic [7:0] regs [12] = '{8'hae, 8'hc0, 8'hc2, 8'hc3, 8'h84, 8'h85,
    8'h94, 8'h95, 8'hac, 8'had, 8'hb4, 8'hb5};
  chip_select_port dut (.*);
  pad_model pads (.*);
  always #5 ref_clk = ~ref_clk;
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // run is about 1000 cycles
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 10000) begin
      bad_count++;
      $display("[FAIL] %0t timeout", $time);
      end_of_test();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1;
    tick(1);
    sfr_wr = 0;
    tick(1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    sfr_addr = a;
    sfr_rd = 1;
    tick(1);
    sfr_rd = 0;
    chk(sfr_rdata_ff, e);
    tick(1);
  endtask
  task automatic setbit(input logic [2:0] s, input logic v);
    bit_sel = s;
    bit_val = v;
    bit_wr = 1;
    tick(1);
    bit_wr = 0;
    tick(1);
  endtask
  task automatic xacc(input logic [15:0] a, input logic w, input int p,
      input logic e, input logic idle);
    xaddr = a;
    xrd_n = w;
    xwr_n = !w;
    tick(2);
    chk({7'h0, pin_in[p]}, {7'h0, e});
    xrd_n = 1;
    xwr_n = 1;
    tick(2);
    chk({7'h0, pin_in[p]}, {7'h0, idle});
  endtask
  task automatic ack_a();
    irq_a_ack = 1;
    tick(1);
    irq_a_ack = 0;
    tick(1);
  endtask
  initial begin
    int span;
    logic [15:0] a;
    logic lvl;
    tick(4);
    arst_n = 1;
    tick(3);
    foreach (regs[i]) rd(regs[i], 8'h00);
    rd(ADDR_PIN_DATA, 8'h0f);
    rd(8'h80, 8'h00);
    chk(8'(sfr_hit), 8'h00);
    wr(ADDR_CFG_LOW, 8'h5a);
    rd(ADDR_CFG_LOW, 8'h5a);
    chk(8'(sfr_hit), 8'h01);
    wr(ADDR_CFG_HIGH, 8'ha5);
    rd(ADDR_CFG_HIGH, 8'ha5);
    wr(ADDR_POLARITY, 8'hff);
    rd(ADDR_POLARITY, 8'hf0);
    $display("register test done");
    wr(ADDR_POLARITY, 8'ha0);
    for (int p = 0; p < 4; p++) begin
      wr(bases[p] + 8'h1, 8'h10 + 8'(p));
      wr(bases[p], 8'h40);
      for (int f = 1; f < 4; f++) begin
        for (int c = 0; c < 4; c++) begin
          wr(p < 2 ? ADDR_CFG_LOW : ADDR_CFG_HIGH,
            8'((f * 4 + c) << (4 * (p % 2))));
          span = c == 3 ? 256 : 1 << c;
          for (int k = 0; k < 4; k++) begin
            a = ((16'h1040 + 16'(p * 256)) | 16'(span - 1)) + 16'(k / 2);
            lvl = (k / 2 == 0) && (k % 2 ? f[1] : f[0]);
            xacc(a, k % 2, p, lvl ~^ p[0], !p[0]);
          end
        end
      end
    end
    wr(ADDR_CFG_LOW, 8'h00);
    wr(ADDR_CFG_HIGH, 8'h00);
    $display("strobe test done");
    wr(ADDR_PIN_DATA, 8'h05);
    rd(ADDR_PIN_DATA, 8'h05);
    chk({4'h0, pin_oe_n}, 8'h05);
    wr(ADDR_PIN_DATA, 8'hff);
    $display("io test done");
    wr(ADDR_XICTL, 8'h0d);
    pull_low = 4'h8;
    tick(3);
    pull_low = 4'h0;
    tick(2);
    chk(8'(irq_a_req), 8'h01);
    chk(8'(irq_a_high), 8'h01);
    chk(8'(irq_b_high), 8'h00);
    rd(ADDR_XICTL, 8'h0f);
    ack_a();
    chk(8'(irq_a_req), 8'h00);
    setbit(3'(XI_A_TRIG), 1'b0);
    pull_low = 4'h8;
    tick(3);
    chk(8'(irq_a_req), 8'h01);
    pull_low = 4'h0;
    tick(3);
    chk(8'(irq_a_req), 8'h00);
    setbit(3'(XI_A_EN), 1'b0);
    pull_low = 4'h8;
    tick(3);
    chk(8'(irq_a_req), 8'h00);
    setbit(3'(XI_B_EN), 1'b1);
    setbit(3'(XI_B_TRIG), 1'b1);
    setbit(3'(XI_B_PRIO), 1'b1);
    pull_low = 4'h4;
    tick(3);
    pull_low = 4'h0;
    tick(2);
    chk(8'(irq_b_req), 8'h01);
    chk(8'(irq_b_high), 8'h01);
    irq_b_ack = 1;
    tick(1);
    irq_b_ack = 0;
    tick(1);
    chk(8'(irq_b_req), 8'h00);
    chk(irq_a_vector, 8'h33);
    chk(irq_b_vector, 8'h3b);
    $display("interrupt test done");
    end_of_test();
  end
endmodule
